// ### rtl/dtfl_terminal_logic.v
`timescale 1ns/1ps
`include "dtfl_map.vh"
// Behaviour
// - Hold-reference latches reference as step base
// - Hold-output overrides start, slip, process loop
// - Raise/lower act only under a hold
// - Raise alone keeps increasing held value
// - Lower wins, keeps decreasing held value
// - 20 ms pulse and pause give one step
// - Steps stay between zero and nominal (output hold) or max reference (reference hold)
// - Setup choice only in multi-setup mode
// - Boost raises, cut or both lower
// - Preset choice needs preset-enable terminal
// - Preset-enable picks external or preset reference
// - Pulse rate maps min to max reference
// - Multiple reference/feedback terminals summed signed
// - Reset-with-start clears alarm and starts
// - Current scaling 0..200, defaults 0/200
// - Voltage scaling 0..100, defaults 0/100
// - Codes 0-11 digital, 12-20 analog
// - Running needs start and speed above 0.1Hz
// - Ready-idle needs ready, no command, no warning
// - Fault on alarm, fault-or-warning on either
// - Direction output high when clockwise
// - Off-bits output under standard profile
// - Current-limit and thermal output choices
module dtfl_terminal_logic #(
  parameter MIN_PULSE_CYC = `DTFL_MIN_PULSE_CYC, // Least pulse, cycles
  parameter VW = 16 // Value width
) (
  input wire clk, // 10 MHz clock
  input wire rst, // Sync reset, high
  input wire [3:0] term_in, // Digital terminals 2..5
  input wire [23:0] term_func, // 6-bit function code per terminal
  input wire [VW-1:0] term_analog, // Signed analog value on terminal 2
  input wire [VW-1:0] pulse_rate, // Measured pulse input rate, Hz
  input wire [VW-1:0] pulse_rate_max, // Rate giving max reference
  input wire [VW-1:0] ref_min, // Minimum reference
  input wire [VW-1:0] ref_max, // Maximum reference
  input wire [VW-1:0] ext_ref, // External reference
  input wire [VW-1:0] preset_ref0, // Preset reference 0
  input wire [VW-1:0] preset_ref1, // Preset reference 1
  input wire [VW-1:0] boost_pct_val, // Boost/cut amount already scaled
  input wire [VW-1:0] out_freq, // Actual output, 0.1 Hz units
  input wire [VW-1:0] nom_freq, // Nominal motor frequency
  input wire [1:0] ref_source, // Reference source code
  input wire multi_setup, // Multi-setup configured
  input wire [1:0] bus_profile, // Fieldbus profile code
  input wire [2:0] off_cmd_bits, // off_cmd_one..three
  input wire unit_ready, // Unit ready
  input wire start_cmd, // Start command present elsewhere
  input wire stop_cmd, // Stop command present
  input wire warning, // Warning active
  input wire alarm, // Alarm active
  input wire on_ref, // Speed at reference
  input wire cur_limit, // Current limit exceeded
  input wire over_temp, // Temperature limit exceeded
  input wire clockwise, // Motor rotates clockwise
  input wire brake_req, // Mechanical brake request
  input wire [2:0] reg_addr, // Parameter index
  input wire reg_wr, // Parameter write strobe
  input wire [7:0] reg_wdata, // Parameter write data
  output reg [7:0] reg_rdata, // Parameter read data
  output reg [VW-1:0] eff_ref, // Effective reference
  output reg [VW-1:0] eff_fb, // Effective feedback
  output reg [VW-1:0] held_val, // Held reference or output
  output reg hold_out_act, // Output hold overrides control
  output reg start_out, // Start to motor control
  output reg alarm_clr, // Alarm reset pulse
  output reg setup_sel, // Active setup
  output reg [7:0] cur_low, // Current low scale
  output reg [7:0] cur_high, // Current high scale
  output reg [7:0] volt_low, // Voltage low scale
  output reg [7:0] volt_high, // Voltage high scale
  output reg term9_dig, // Terminal 9 digital level
  output reg term9_an_en, // Terminal 9 in analog mode
  output reg term9_live0, // Analog 4-20 mA offset
  output reg [VW-1:0] term9_an // Terminal 9 analog quantity
);
  // ****************************************
  // Terminal function decode
  // ****************************************
  reg [7:0] out_func_r; // Output function code
  reg [3:0] sync1_r; // First sync stage
  reg [3:0] sync2_r; // Second sync stage
  reg [3:0] lvl; // Function levels
  reg [3:0] sel; // Function selected bits
  reg pre_en_sel, pre_en, pre_ch, boost, cut, rs_lvl, st_lvl, setup_lvl;
  reg pulse_sel, pulse_fb_sel;
  integer i;
  // Terminals are synchronised before use
  // Only the second stage feeds the decode, so no metastable read
  always @(posedge clk) begin
    if (rst) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else begin
      sync1_r <= term_in;
      sync2_r <= sync1_r;
    end
  end
  // Decode which terminal carries which function
  // A function set on several terminals acts when any of them is high
  always @* begin
    lvl = 4'h0;
    sel = 4'h0;
    pre_en_sel = 1'b0;
    pre_en = 1'b0;
    pre_ch = 1'b0;
    boost = 1'b0;
    cut = 1'b0;
    rs_lvl = 1'b0;
    st_lvl = 1'b0;
    setup_lvl = 1'b0;
    pulse_sel = 1'b0;
    pulse_fb_sel = 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      case (term_func[i*6 +: 6])
        `DTFL_FN_HOLD_REF: begin
          sel[0] = 1'b1;
          lvl[0] = lvl[0] | sync2_r[i];
        end
        `DTFL_FN_HOLD_OUT: begin
          sel[1] = 1'b1;
          lvl[1] = lvl[1] | sync2_r[i];
        end
        `DTFL_FN_RAISE: lvl[2] = lvl[2] | sync2_r[i];
        `DTFL_FN_LOWER: lvl[3] = lvl[3] | sync2_r[i];
        `DTFL_FN_SETUP: setup_lvl = setup_lvl | sync2_r[i];
        `DTFL_FN_BOOST: boost = boost | sync2_r[i];
        `DTFL_FN_CUT: cut = cut | sync2_r[i];
        `DTFL_FN_PRESET: pre_ch = pre_ch | sync2_r[i];
        `DTFL_FN_PRESET_ON: begin
          pre_en_sel = 1'b1;
          pre_en = pre_en | sync2_r[i];
        end
        `DTFL_FN_PULSE_REF: pulse_sel = 1'b1;
        `DTFL_FN_PULSE_FB: pulse_fb_sel = 1'b1;
        `DTFL_FN_START: st_lvl = st_lvl | sync2_r[i];
        `DTFL_FN_RST_START: rs_lvl = rs_lvl | sync2_r[i];
        default: begin
        end
      endcase
    end
  end
  // ****************************************
  // Reference forming
  // ****************************************
  reg [VW-1:0] base_ref; // Reference before boost/cut
  reg [VW-1:0] sum_ref; // Signed sum of analog references
  reg [VW-1:0] sum_fb; // Signed sum of analog feedbacks
  reg [VW-1:0] pulse_ref; // Reference from pulse rate
  reg [2*VW-1:0] prod; // Scaling product
  reg [VW-1:0] span; // Reference span
  // Analog terminal 2 only carries reference/feedback
  always @* begin
    sum_ref = {VW{1'b0}};
    sum_fb = {VW{1'b0}};
    if (term_func[5:0] == `DTFL_FN_AN_REF)
      sum_ref = term_analog;
    if (term_func[5:0] == `DTFL_FN_AN_FB)
      sum_fb = term_analog;
    span = ref_max - ref_min;
    // Pulse rate scaled linearly from 0 Hz up to configured rate
    // A zero full-scale rate would divide by zero, so it gives full span
    if (pulse_rate >= pulse_rate_max || pulse_rate_max == {VW{1'b0}})
      prod = {{VW{1'b0}}, span};
    else
      prod = (span * pulse_rate) / pulse_rate_max;
    pulse_ref = ref_min + prod[VW-1:0];
    if (pulse_sel)
      sum_ref = sum_ref + pulse_ref;
    if (pulse_fb_sel)
      sum_fb = sum_fb + pulse_rate;
    // Preset choice only counts with preset-enable present
    if (ref_source == 2'h2 && pre_en_sel && pre_en)
      base_ref = pre_ch ? preset_ref1 : preset_ref0;
    else
      base_ref = ext_ref + sum_ref;
  end
  // ****************************************
  // Raise/lower pulse filter
  // ****************************************
  reg [31:0] hi_cnt_r; // Cycles the active input is high
  reg [31:0] lo_cnt_r; // Cycles since last release
  reg armed_r; // Pause was long enough
  reg step_up_r, step_dn_r; // One-cycle step strobes
  // A hold counts only where its function is selected on a terminal
  wire any_hold = (sel[0] & lvl[0]) | (sel[1] & lvl[1]);
  wire dn_req = lvl[3];
  wire up_req = lvl[2] & ~lvl[3];
  wire ud = (up_req | dn_req) & any_hold;
  // A step repeats every min pulse while held, so holding ramps
  always @(posedge clk) begin
    if (rst) begin
      hi_cnt_r <= 32'h0;
      lo_cnt_r <= 32'h0;
      armed_r <= 1'b1;
      step_up_r <= 1'b0;
      step_dn_r <= 1'b0;
    end else begin
      step_up_r <= 1'b0;
      step_dn_r <= 1'b0;
      if (ud) begin
        // Steps are counted only after reset or a full pause armed the filter
        lo_cnt_r <= 32'h0;
        if (armed_r && hi_cnt_r == MIN_PULSE_CYC - 1) begin
          hi_cnt_r <= 32'h0;
          step_up_r <= up_req;
          step_dn_r <= dn_req;
        end else if (armed_r) begin
          hi_cnt_r <= hi_cnt_r + 32'h1;
        end
      end else begin
        // A release restarts the high count, so short pulses never step
        hi_cnt_r <= 32'h0;
        if (lo_cnt_r == MIN_PULSE_CYC - 1)
          armed_r <= 1'b1;
        else begin
          // Pause still too short: keep the filter disarmed
          lo_cnt_r <= lo_cnt_r + 32'h1;
          armed_r <= 1'b0;
        end
      end
    end
  end
  // ****************************************
  // Held value and outputs to control
  // ****************************************
  reg hold_prev_r; // Hold was active last cycle
  reg rs_prev_r; // Reset-with-start last level
  reg kind_prev_r; // Output hold was the kind last cycle
  wire [VW-1:0] step = lvl[1] ? `DTFL_STEP_DHZ : `DTFL_STEP_REF;
  // Upper limit follows the held quantity: frequency or reference
  wire [VW-1:0] top = lvl[1] ? nom_freq : ref_max;
  always @(posedge clk) begin
    if (rst) begin
      held_val <= {VW{1'b0}};
      hold_prev_r <= 1'b0;
      rs_prev_r <= 1'b0;
      kind_prev_r <= 1'b0;
      eff_ref <= {VW{1'b0}};
      eff_fb <= {VW{1'b0}};
      hold_out_act <= 1'b0;
      start_out <= 1'b0;
      alarm_clr <= 1'b0;
      setup_sel <= 1'b0;
    end else begin
      hold_prev_r <= any_hold;
      rs_prev_r <= rs_lvl;
      kind_prev_r <= lvl[1];
      // Capture the base on the rising edge of a hold, and again when
      // the kind of hold changes, so the base matches what is held
      if (any_hold && (!hold_prev_r || kind_prev_r != lvl[1]))
        held_val <= lvl[1] ? out_freq : base_ref;
      // Lower is tested first so it wins over raise
      else if (step_dn_r)
        held_val <= (held_val > step) ? held_val - step
                                      : {VW{1'b0}};
      else if (step_up_r)
        // Compared as a distance so a value near full scale cannot wrap
        held_val <= (held_val < top && top - held_val > step)
                    ? held_val + step : top;
      // Boost/cut: cut wins when both are high
      if (lvl[0])
        eff_ref <= held_val;
      else if (cut)
        eff_ref <= base_ref - boost_pct_val;
      else if (boost)
        eff_ref <= base_ref + boost_pct_val;
      else
        eff_ref <= base_ref;
      eff_fb <= sum_fb;
      hold_out_act <= lvl[1];
      // Held output ignores start and stand-by changes
      if (!lvl[1])
        start_out <= start_cmd | st_lvl | rs_lvl;
      // One pulse per activation, while the start level stays
      alarm_clr <= rs_lvl & ~rs_prev_r;
      if (multi_setup)
        setup_sel <= setup_lvl;
    end
  end
  // ****************************************
  // Scaling parameters
  // ****************************************
  wire in_cur = reg_wdata <= `DTFL_CUR_MAX;
  wire in_volt = reg_wdata <= `DTFL_VOLT_MAX;
  // Out-of-range writes are dropped, old value stays
  // The output code is kept as written; unknown codes decode as none
  always @(posedge clk) begin
    if (rst) begin
      cur_low <= `DTFL_RST_CUR_LOW;
      cur_high <= `DTFL_RST_CUR_HIGH;
      volt_low <= `DTFL_RST_VOLT_LOW;
      volt_high <= `DTFL_RST_VOLT_HIGH;
      out_func_r <= `DTFL_RST_OUT_FUNC;
    end else if (reg_wr) begin
      case (reg_addr)
        `DTFL_REG_CUR_LOW: if (in_cur) cur_low <= reg_wdata;
        `DTFL_REG_CUR_HIGH: if (in_cur) cur_high <= reg_wdata;
        `DTFL_REG_VOLT_LOW: if (in_volt) volt_low <= reg_wdata;
        `DTFL_REG_VOLT_HIGH: if (in_volt) volt_high <= reg_wdata;
        `DTFL_REG_OUT_FUNC: out_func_r <= reg_wdata;
        default: begin
        end
      endcase
    end
  end
  // Read mux, unmapped indices read zero
  always @* begin
    case (reg_addr)
      `DTFL_REG_CUR_LOW: reg_rdata = cur_low;
      `DTFL_REG_CUR_HIGH: reg_rdata = cur_high;
      `DTFL_REG_VOLT_LOW: reg_rdata = volt_low;
      `DTFL_REG_VOLT_HIGH: reg_rdata = volt_high;
      `DTFL_REG_OUT_FUNC: reg_rdata = out_func_r;
      default: reg_rdata = 8'h00;
    endcase
  end
  // ****************************************
  // Terminal 9 output
  // ****************************************
  // Strictly above one unit of 0.1 Hz
  wire running = start_out && (out_freq > `DTFL_RUN_MIN_DHZ);
  reg dig_nxt; // Digital level choice
  always @* begin
    case (out_func_r)
      `DTFL_OF_READY: dig_nxt = unit_ready;
      `DTFL_OF_IDLE: dig_nxt = unit_ready & ~start_out & ~stop_cmd
                               & ~warning;
      `DTFL_OF_RUN: dig_nxt = running;
      `DTFL_OF_RUN_NW: dig_nxt = running & ~warning;
      `DTFL_OF_ON_REF: dig_nxt = on_ref & ~warning;
      `DTFL_OF_FAULT: dig_nxt = alarm;
      `DTFL_OF_FAULT_W: dig_nxt = alarm | warning;
      `DTFL_OF_ILIM: dig_nxt = cur_limit;
      `DTFL_OF_THERM: dig_nxt = over_temp;
      `DTFL_OF_DIR: dig_nxt = clockwise;
      `DTFL_OF_OFFB: dig_nxt = (bus_profile == `DTFL_PROFILE_STD)
                               & (|off_cmd_bits);
      `DTFL_OF_LAST: dig_nxt = brake_req;
      default: dig_nxt = 1'b0;
    endcase
  end
  // Analog quantities by code pair; odd code selects 4-20 mA
  always @(posedge clk) begin
    if (rst) begin
      term9_dig <= 1'b0;
      term9_an_en <= 1'b0;
      term9_live0 <= 1'b0;
      term9_an <= {VW{1'b0}};
    end else begin
      term9_dig <= dig_nxt;
      term9_an_en <= (out_func_r >= `DTFL_OF_AN_FIRST) &&
                     (out_func_r <= `DTFL_OF_LAST);
      term9_live0 <= out_func_r[0];
      case (out_func_r[4:1])
        4'h6: term9_an <= out_freq;
        4'h7: term9_an <= eff_ref;
        4'h8: term9_an <= eff_fb;
        4'h9: term9_an <= {{(VW-1){1'b0}}, cur_limit};
        // Brake request drives full scale or zero in analog mode
        4'ha: term9_an <= {VW{brake_req}};
        default: term9_an <= {VW{1'b0}};
      endcase
    end
  end
endmodule

// ### shared/dtfl_map.vh
`ifndef DTFL_MAP_VH
`define DTFL_MAP_VH
// ****************************************
// Terminal function codes
// ****************************************
`define DTFL_FN_START 6'h07
`define DTFL_FN_HOLD_REF 6'h0e
`define DTFL_FN_HOLD_OUT 6'h0f
`define DTFL_FN_RAISE 6'h10
`define DTFL_FN_LOWER 6'h11
`define DTFL_FN_SETUP 6'h12
`define DTFL_FN_BOOST 6'h13
`define DTFL_FN_CUT 6'h14
`define DTFL_FN_PRESET 6'h15
`define DTFL_FN_PRESET_ON 6'h16
`define DTFL_FN_PULSE_REF 6'h18
`define DTFL_FN_PULSE_FB 6'h19
`define DTFL_FN_AN_REF 6'h1e
`define DTFL_FN_AN_FB 6'h1f
`define DTFL_FN_RST_START 6'h20
// ****************************************
// Register indices and reset values
// ****************************************
`define DTFL_REG_CUR_LOW 3'h0
`define DTFL_REG_CUR_HIGH 3'h1
`define DTFL_REG_VOLT_LOW 3'h2
`define DTFL_REG_VOLT_HIGH 3'h3
`define DTFL_REG_OUT_FUNC 3'h4
`define DTFL_RST_CUR_LOW 8'h00
`define DTFL_RST_CUR_HIGH 8'hc8
`define DTFL_RST_VOLT_LOW 8'h00
`define DTFL_RST_VOLT_HIGH 8'h64
`define DTFL_RST_OUT_FUNC 8'h00
`define DTFL_CUR_MAX 8'hc8
`define DTFL_VOLT_MAX 8'h64
// ****************************************
// Output function codes and constants
// ****************************************
`define DTFL_OF_READY 8'h01
`define DTFL_OF_IDLE 8'h02
`define DTFL_OF_RUN 8'h03
`define DTFL_OF_RUN_NW 8'h04
`define DTFL_OF_ON_REF 8'h05
`define DTFL_OF_FAULT 8'h06
`define DTFL_OF_FAULT_W 8'h07
`define DTFL_OF_ILIM 8'h08
`define DTFL_OF_THERM 8'h09
`define DTFL_OF_DIR 8'h0a
`define DTFL_OF_OFFB 8'h0b
`define DTFL_OF_AN_FIRST 8'h0c
`define DTFL_OF_LAST 8'h14
`define DTFL_PROFILE_STD 2'h0
`define DTFL_MIN_PULSE_MS 20
`define DTFL_CLK_KHZ 10000
`define DTFL_MIN_PULSE_CYC (`DTFL_MIN_PULSE_MS * `DTFL_CLK_KHZ)
`define DTFL_RUN_MIN_DHZ 16'h0001
`define DTFL_STEP_REF 16'h0001
`define DTFL_STEP_DHZ 16'h0001
`endif

// ### verification/dtfl_monitor.sv
`timescale 1ns/1ps
// ****************************************
// Port checker for the terminal logic
// ****************************************
module dtfl_monitor (
  input wire clk, // Drive clock
  input wire rst, // Sync reset, high
  input wire [2:0] reg_addr, // Parameter index
  input wire reg_wr, // Write strobe
  input wire [7:0] reg_wdata, // Write data
  input wire [7:0] reg_rdata, // Read data
  input wire [7:0] cur_low, // Current low scale
  input wire [7:0] cur_high, // Current high scale
  input wire [7:0] volt_high, // Voltage high scale
  input wire alarm, // Alarm level
  input wire alarm_clr, // Alarm clear pulse
  input wire start_out, // Start to motor control
  input wire term9_dig, // Output digital level
  input wire term9_an_en // Output analog mode
);
  // All checks rest while reset is high
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_clr_one_cycle: assert property (alarm_clr |=> !alarm_clr)
    else $error("alarm clear longer than one cycle");
  a_clr_with_start: assert property (alarm_clr |-> ##[0:2] start_out)
    else $error("alarm clear without start");
  a_cur_refused: assert property (reg_wr && reg_addr == 3'h0
    && reg_wdata > 8'hc8 |=> $stable(cur_low)) else $error("bad cur low taken");
  a_volt_refused: assert property (reg_wr && reg_addr == 3'h3
    && reg_wdata > 8'h64 |=> $stable(volt_high)) else $error("bad volt taken");
  a_cur_write: assert property (reg_wr && reg_addr == 3'h1
    && reg_wdata <= 8'hc8 |=> cur_high == $past(reg_wdata))
    else $error("cur high not written");
  a_out_inactive: assert property (reg_wr && reg_addr == 3'h4
    && reg_wdata > 8'h14 |-> ##2 !term9_dig && !term9_an_en)
    else $error("unknown output code drives output");
  a_out_analog: assert property (reg_wr && reg_addr == 3'h4
    && reg_wdata inside {[8'h0c:8'h14]} |-> ##2 term9_an_en)
    else $error("analog code left output digital");
  a_fault_out: assert property ((reg_addr == 3'h4
    && reg_rdata == 8'h06 && alarm) [*3] |-> term9_dig)
    else $error("fault output missing");
  c_clear: cover property (alarm_clr);
  c_refused: cover property (reg_wr && reg_addr == 3'h0 && reg_wdata > 8'hc8);
  c_analog: cover property (term9_an_en);
endmodule
bind dtfl_terminal_logic dtfl_monitor i_mon (.*);

// ### verification/dtfl_switch_model.sv
`timescale 1ns/1ps
// ****************************************
// Switches and pulse source on terminals 2..5
// ****************************************
module dtfl_switch_model (
  input wire clk, // Drive clock
  input wire [3:0] lvl, // Static switch levels
  input wire [3:0] pmask, // Terminals that pulse
  input wire [7:0] pw, // High and pause length, cycles
  input wire [3:0] pn, // Pulses in a burst
  input wire pgo, // Start a burst
  output wire [3:0] term_in, // Levels to the drive
  output wire pbusy // Burst in progress
);
  reg [8:0] cnt_r = 9'h000; // Place in one pulse period
  reg [3:0] left_r = 4'h0; // Pulses still to send
  // High phase equals pause, so both meet one length
  wire high_ph = (cnt_r < {1'b0, pw}) && (left_r != 4'h0);
  assign term_in = lvl | (high_ph ? pmask : 4'h0);
  assign pbusy = (left_r != 4'h0);
  // Period counter, one period per pulse
  always @(posedge clk) begin
    if (pgo) begin
      cnt_r <= 9'h000;
      left_r <= pn;
    end else if (pbusy) begin
      if (cnt_r + 9'h001 == {pw, 1'b0}) begin
        cnt_r <= 9'h000;
        left_r <= left_r - 4'h1;
      end else begin
        cnt_r <= cnt_r + 9'h001;
      end
    end
  end
endmodule

// ### verification/dtfl_terminal_logic_tb.sv
`timescale 1ns/1ps
`include "dtfl_map.vh"
// ****************************************
// Terminal logic bench
// ****************************************
module dtfl_terminal_logic_tb;
  reg clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, pgo = 1'b0; // Clock, strobes
  reg multi_setup = 1'b0, start_cmd = 1'b0, stop_cmd = 1'b0; // Commands
  reg on_ref = 1'b0, brake_req = 1'b0; // Spare status
  reg [5:0] st = 6'h00; // Status levels
  reg [23:0] term_func = 24'h0; // Terminal codes
  reg [15:0] term_analog = 16'h0, pulse_rate = 16'h0, out_freq = 16'h0;
  reg [15:0] pulse_rate_max = 16'h03e8, ref_min = 16'h0010;
  reg [15:0] ref_max = 16'h0400, ext_ref = 16'h0100;
  reg [15:0] preset_ref0 = 16'h0200, preset_ref1 = 16'h0300;
  reg [15:0] boost_pct_val = 16'h0010, nom_freq = 16'h01f4;
  reg [1:0] ref_source = 2'h0, bus_profile = 2'h0; // Mode codes
  reg [2:0] off_cmd_bits = 3'h0, reg_addr = 3'h0; // Control bits, index
  reg [7:0] reg_wdata = 8'h00, pw = 8'h0c; // Write data, pulse length
  reg [3:0] lvl = 4'h0, pmask = 4'h0, pn = 4'h0; // Switch controls
  wire unit_ready = st[0], alarm = st[1], warning = st[2];
  wire cur_limit = st[3], over_temp = st[4], clockwise = st[5];
  wire [7:0] reg_rdata, cur_low, cur_high, volt_low, volt_high;
  wire [15:0] eff_ref, eff_fb, held_val, term9_an;
  wire hold_out_act, start_out, alarm_clr, setup_sel, pbusy;
  wire term9_dig, term9_an_en, term9_live0;
  wire [3:0] term_in; // Terminal levels from the switches
  integer bad_count = 0, compares = 0, i, k;
  // Short pulse time keeps the run brief
  dtfl_terminal_logic #(.MIN_PULSE_CYC(10)) i_dut (.*);
  dtfl_switch_model i_sw (.*);
  // 10 MHz clock
  always #50 clk = ~clk;
  // ****************************************
  // Shared tasks
  // ****************************************
  task test_done; begin
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end endtask
  task expire; begin
    bad_count = bad_count + 1;
    $display("MISMATCH wait expected done seen busy");
    test_done;
  end endtask
  task tick(input integer n); begin
    repeat (n) @(posedge clk);
    #1;
  end endtask
  task chk(input string nm, input [15:0] e, input [15:0] g); begin
    compares = compares + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("MISMATCH %0s expected %h seen %h", nm, e, g);
    end
  end endtask
  // One parameter write, strobe held for one edge
  task wr(input [2:0] a, input [7:0] d); begin
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    tick(2);
  end endtask
  // Pulse burst, then a pause longer than the least pulse time
  task burst(input [3:0] m, input [7:0] w, input [3:0] n); begin
    @(posedge clk);
    pmask <= m;
    pw <= w;
    pn <= n;
    pgo <= 1'b1;
    @(posedge clk);
    pgo <= 1'b0;
    #1;
    k = 0;
    while (pbusy === 1'b1 && k < 900) begin
      tick(1);
      k = k + 1;
    end
    if (k >= 900) expire;
    tick(12);
  end endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_regs;
    reg [39:0] rv;
    begin
      rv = {8'h00, 8'h64, 8'h00, 8'hc8, 8'h00};
      for (i = 0; i < 5; i = i + 1) begin
        @(posedge clk);
        reg_addr <= i[2:0];
        tick(1);
        chk("reset value", {8'h00, rv[8*i+:8]}, reg_rdata);
      end
      wr(3'h0, 8'hc9);
      chk("cur low", 16'h0, cur_low);
      wr(3'h0, 8'hc8);
      chk("cur low", 16'h00c8, cur_low);
      wr(3'h0, 8'h28);
      chk("read back", 16'h0028, reg_rdata);
      wr(3'h3, 8'h65);
      chk("volt high", 16'h0064, volt_high);
      wr(3'h2, 8'h64);
      chk("volt low", 16'h0064, volt_low);
      wr(3'h5, 8'hff);
      chk("unmapped", 16'h0028, cur_low);
      wr(3'h1, 8'h00);
      chk("cur high", 16'h0, cur_high);
    end
  endtask
  task t_out;
    reg [47:0] code;
    begin
      code = {8'h0a, 8'h09, 8'h08, 8'h07, 8'h06, 8'h01};
      for (i = 0; i < 6; i = i + 1) begin
        wr(3'h4, code[8*i+:8]);
        chk("out idle", 16'h0, term9_dig);
        @(posedge clk);
        st <= 6'h01 << i;
        tick(3);
        chk("out set", 16'h1, term9_dig);
        @(posedge clk);
        st <= 6'h00;
      end
      wr(3'h4, 8'h02);
      st <= 6'h01;
      tick(3);
      chk("ready idle", 16'h1, term9_dig);
      stop_cmd <= 1'b1;
      tick(3);
      chk("ready idle", 16'h0, term9_dig);
      wr(3'h4, 8'h03);
      stop_cmd <= 1'b0;
      start_cmd <= 1'b1;
      out_freq <= 16'h1;
      tick(3);
      chk("running", 16'h0, term9_dig);
      out_freq <= 16'h2;
      tick(3);
      chk("running", 16'h1, term9_dig);
      wr(3'h4, 8'h04);
      st <= 6'h05;
      tick(3);
      chk("run no warn", 16'h0, term9_dig);
      wr(3'h4, 8'h0b);
      off_cmd_bits <= 3'h4;
      tick(3);
      chk("off bits", 16'h1, term9_dig);
      bus_profile <= 2'h1;
      tick(3);
      chk("off bits", 16'h0, term9_dig);
      chk("digital", 16'h0, term9_an_en);
      st <= 6'h3f;
      wr(3'h4, 8'h19);
      chk("no code", 16'h0, {term9_an_en, term9_dig});
      wr(3'h4, 8'h0c);
      chk("analog", 16'h2, {term9_an_en, term9_live0});
      chk("an freq", 16'h0002, term9_an);
      wr(3'h4, 8'h13);
      chk("analog", 16'h3, {term9_an_en, term9_live0});
      chk("an current", 16'h0001, term9_an);
      brake_req <= 1'b1;
      wr(3'h4, 8'h14);
      chk("brake", 16'h2, {term9_an_en, term9_live0});
      chk("brake level", 16'hffff, term9_an);
      brake_req <= 1'b0;
      st <= 6'h00;
      start_cmd <= 1'b0;
    end
  endtask
  task t_updown; begin
    @(posedge clk);
    term_func <= {6'h0, `DTFL_FN_LOWER, `DTFL_FN_RAISE, 6'h0};
    burst(4'h2, 8'h0c, 4'h2);
    chk("no hold", 16'h0, held_val);
    term_func[5:0] <= `DTFL_FN_HOLD_REF;
    lvl <= 4'h1;
    tick(12);
    chk("held base", 16'h0100, held_val);
    burst(4'h2, 8'h0c, 4'h3);
    chk("raise", 16'h0103, held_val);
    burst(4'h6, 8'h0c, 4'h2);
    chk("lower wins", 16'h0101, held_val);
    burst(4'h2, 8'h05, 4'h3);
    chk("short", 16'h0101, held_val);
    lvl <= 4'h3;
    tick(40);
    chk("raise held", 16'h1, {15'h0, held_val > 16'h0101});
    term_func[5:0] <= `DTFL_FN_HOLD_OUT;
    lvl <= 4'h1;
    tick(6);
    chk("hold out", 16'h1, hold_out_act);
    start_cmd <= 1'b1;
    tick(4);
    chk("hold start", 16'h0, start_out);
    start_cmd <= 1'b0;
  end endtask
  task t_ref; begin
    @(posedge clk);
    term_func <= {`DTFL_FN_CUT, `DTFL_FN_BOOST, 12'h0};
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clk);
      lvl <= {i[1:0], 2'b00};
      tick(6);
      chk("boost cut", i == 0 ? 16'h0100 : i == 1 ? 16'h0110 : 16'h00f0,
        eff_ref);
    end
    ref_source <= 2'h2;
    term_func <= {`DTFL_FN_PRESET, `DTFL_FN_PRESET_ON, 12'h0};
    lvl <= 4'h8;
    tick(6);
    chk("ext ref", 16'h0100, eff_ref);
    lvl <= 4'h4;
    tick(6);
    chk("preset 0", 16'h0200, eff_ref);
    lvl <= 4'hc;
    tick(6);
    chk("preset 1", 16'h0300, eff_ref);
    term_func[17:12] <= 6'h0;
    tick(6);
    chk("no enable", 16'h0100, eff_ref);
    ref_source <= 2'h0;
    // External reference is summed in, so zero it for the pulse cases
    ext_ref <= 16'h0000;
    lvl <= 4'h0;
    term_func <= {12'h0, `DTFL_FN_PULSE_REF, 6'h0};
    tick(6);
    chk("pulse min", 16'h0010, eff_ref);
    pulse_rate <= 16'h03e8;
    tick(6);
    chk("pulse max", 16'h0400, eff_ref);
    term_func <= {12'h0, `DTFL_FN_PULSE_FB, `DTFL_FN_AN_FB};
    term_analog <= 16'h0005;
    tick(6);
    chk("fb sum", 16'h03ed, eff_fb);
    term_func <= {`DTFL_FN_SETUP, 18'h0};
    lvl <= 4'h8;
    tick(6);
    chk("setup", 16'h0, setup_sel);
    multi_setup <= 1'b1;
    tick(6);
    chk("setup", 16'h1, setup_sel);
    term_func <= {`DTFL_FN_RST_START, 18'h0};
    lvl <= 4'h0;
    st <= 6'h02;
    tick(6);
    lvl <= 4'h8;
    k = 0;
    while (alarm_clr !== 1'b1 && k < 20) begin
      tick(1);
      k = k + 1;
    end
    if (k >= 20) expire;
    tick(2);
    chk("reset start", 16'h1, start_out);
  end endtask
  // Reset for two cycles, then every scenario in turn
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    t_regs;
    t_out;
    t_updown;
    t_ref;
    test_done;
  end
endmodule
